// File: design/pppr_top.sv
/*
 * transceiver power policy register bank: control and analog config
 * registers on axi4-lite, nvm-sourced defaults, policy outputs.
 * assumes synchronous inputs, one 50 mhz clock, lan reset active high.
 */
`default_nettype none
module pppr_top
   import pppr_pkg::*;
(
   input  wire logic                   CLOCK_IN,
   input  wire logic                   RST_IN,
   input  wire logic                   CE_IN,
   // axi4-lite slave
   input  wire logic [PPPR_ADDR_W-1:0] S_AXI_AWADDR_IN,
   input  wire logic                   S_AXI_AWVALID_IN,
   output logic                        S_AXI_AWREADY_OUT,
   input  wire logic [31:0]            S_AXI_WDATA_IN,
   input  wire logic [3:0]             S_AXI_WSTRB_IN,
   input  wire logic                   S_AXI_WVALID_IN,
   output logic                        S_AXI_WREADY_OUT,
   output logic [1:0]                  S_AXI_BRESP_OUT,
   output logic                        S_AXI_BVALID_OUT,
   input  wire logic                   S_AXI_BREADY_IN,
   input  wire logic [PPPR_ADDR_W-1:0] S_AXI_ARADDR_IN,
   input  wire logic                   S_AXI_ARVALID_IN,
   output logic                        S_AXI_ARREADY_OUT,
   output logic [31:0]                 S_AXI_RDATA_OUT,
   output logic [1:0]                  S_AXI_RRESP_OUT,
   output logic                        S_AXI_RVALID_OUT,
   input  wire logic                   S_AXI_RREADY_IN,
   // nvm port
   output pppr_nvm_req_t               NVM_REQ_OUT,
   input  wire pppr_nvm_rsp_t          NVM_RSP_IN,
   // transceiver side
   input  wire logic                   VARIANT_VALID_IN,
   input  wire logic [POL_VAR_W-1:0]   VARIANT_CODE_IN,
   input  wire pppr_pwr_t              POWER_STATE_IN,
   input  wire logic                   LINK_UP_IN,
   output pppr_policy_t                POLICY_OUT,
   // general-purpose unit
   output logic                        INVERT_RX_OUT,
   output logic [ANA_VSEL_W-1:0]       VOLTAGE_SEL_OUT
);
   // ==========================================================
   // declarations
   logic [15:0]           nvm_word;
   logic                  pol_ld;
   logic                  ana_ld;
   logic                  ld_done;
   logic [POL_VAR_W-1:0]  var_code;
   logic                  var_done;
   logic                  spd_r, slow_all_r, slow_nact_r, gig_nact_r, gig_all_r, b2b_r;
   logic                  bs_act_r, no_auto_r;
   logic [3:0]            rsv_r;
   logic                  inv_rx_r;
   logic [ANA_VSEL_W-1:0] vsel_r;
   logic                  aw_hold_r, w_hold_r;
   logic [PPPR_ADDR_W-1:0] awaddr_r;
   logic [31:0]           wdata_r;
   logic [3:0]            wstrb_r;
   logic                  wr_fire;
   logic                  rd_fire;
   logic [31:0]           pol_word;
   logic [31:0]           ana_word;
   logic [31:0]           rd_nxt;
   logic                  rd_hit;
   logic                  wr_pol, wr_ana;
   logic                  active_state;
   logic                  d3_state;
   logic                  auto_saver;

   // ==========================================================
   // submodules
   pppr_nvm_loader u_loader (
      .clk_in        (CLOCK_IN),
      .rst_in        (RST_IN),
      .ce_in         (CE_IN),
      .nvm_req_out   (NVM_REQ_OUT),
      .nvm_rsp_in    (NVM_RSP_IN),
      .word_out      (nvm_word),
      .policy_ld_out (pol_ld),
      .analog_ld_out (ana_ld),
      .done_out      (ld_done)
   );

   pppr_variant_read #(.W(POL_VAR_W)) u_variant (
      .clk_in   (CLOCK_IN),
      .rst_in   (RST_IN),
      .ce_in    (CE_IN),
      .valid_in (VARIANT_VALID_IN),
      .code_in  (VARIANT_CODE_IN),
      .code_out (var_code),
      .done_out (var_done)
   );

   // ==========================================================
   // axi write channel capture, either order; readies low while frozen
   assign S_AXI_AWREADY_OUT = CE_IN && !aw_hold_r && !S_AXI_BVALID_OUT;
   assign S_AXI_WREADY_OUT  = CE_IN && !w_hold_r && !S_AXI_BVALID_OUT;
   assign wr_fire = aw_hold_r && w_hold_r && !S_AXI_BVALID_OUT;

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         aw_hold_r <= 1'b0;
         awaddr_r  <= '0;
      end else if (CE_IN) begin
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= S_AXI_AWADDR_IN;
         end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         w_hold_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else if (CE_IN) begin
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_hold_r <= 1'b1;
            wdata_r  <= S_AXI_WDATA_IN;
            wstrb_r  <= S_AXI_WSTRB_IN;
         end else if (wr_fire) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   // write response: slverr for unmapped
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         S_AXI_BVALID_OUT <= 1'b0;
         S_AXI_BRESP_OUT  <= AXI_OKAY;
      end else if (CE_IN) begin
         if (wr_fire) begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT  <= (wr_pol || wr_ana || awaddr_r == PPPR_OFS_STATUS ||
                                 awaddr_r == PPPR_OFS_NVM) ? AXI_OKAY : AXI_SLVERR;
         end else if (S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
         end
      end
   end

   assign wr_pol = wr_fire && (awaddr_r == PPPR_OFS_POLICY);
   assign wr_ana = wr_fire && (awaddr_r == PPPR_OFS_ANALOG);

   // ==========================================================
   // policy register, low byte (bits 7:0)
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         spd_r       <= 1'b0;
         slow_all_r  <= 1'b0;
         slow_nact_r <= 1'b0;
         gig_nact_r  <= 1'b0;
         gig_all_r   <= 1'b0;
         b2b_r       <= 1'b0;
      end else if (CE_IN) begin
         if (pol_ld) begin
            spd_r       <= nvm_word[NVM_SPD];
            slow_all_r  <= nvm_word[NVM_SLOW_ALL];
            slow_nact_r <= nvm_word[NVM_SLOW_NACT];
            gig_nact_r  <= nvm_word[NVM_GIG_NACT];
            gig_all_r   <= nvm_word[NVM_GIG_ALL];
            b2b_r       <= nvm_word[NVM_B2B];
         end else if (wr_pol && wstrb_r[0]) begin
            spd_r       <= wdata_r[POL_SPD_EN];
            slow_all_r  <= wdata_r[POL_SLOW_ALL];
            slow_nact_r <= wdata_r[POL_SLOW_NACT];
            gig_nact_r  <= wdata_r[POL_GIG_NACT];
            gig_all_r   <= wdata_r[POL_GIG_ALL];
            b2b_r       <= wdata_r[POL_B2B_EN];
         end
      end
   end

   // policy register, upper control bits
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         bs_act_r  <= 1'b0;
         rsv_r     <= POL_RSV_RESET;
         no_auto_r <= 1'b0;
      end else if (CE_IN && wr_pol) begin
         if (wstrb_r[2]) begin
            bs_act_r  <= wdata_r[POL_BS_ACT];
            no_auto_r <= wdata_r[POL_NO_AUTO];
         end
      end
   end

   // ==========================================================
   // analog config register
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         inv_rx_r <= 1'b0;
         vsel_r   <= ANA_VSEL_RESET;
      end else if (CE_IN) begin
         if (ana_ld) begin
            inv_rx_r <= nvm_word[NVM_INV_RX];
         end else if (wr_ana && wstrb_r[0]) begin
            inv_rx_r <= wdata_r[ANA_INV_RX];
            vsel_r   <= wdata_r[ANA_VSEL_LO +: ANA_VSEL_W];
         end
      end
   end

   // ==========================================================
   // read data assembly
   always_comb begin
      pol_word = '0;
      pol_word[POL_SPD_EN]    = spd_r;
      pol_word[POL_SLOW_ALL]  = slow_all_r;
      pol_word[POL_SLOW_NACT] = slow_nact_r;
      pol_word[POL_GIG_NACT]  = gig_nact_r;
      pol_word[POL_GIG_ALL]   = gig_all_r;
      pol_word[POL_B2B_EN]    = b2b_r;
      pol_word[POL_BS_ACT]    = bs_act_r;
      pol_word[POL_RSV_LO +: 4] = rsv_r;
      pol_word[POL_NO_AUTO]   = no_auto_r;
      pol_word[POL_VAR_DONE]  = var_done;
      pol_word[POL_VAR_LO +: POL_VAR_W] = var_code;
   end

   // upper bits stay zero, writes dropped
   always_comb begin
      ana_word = '0;
      ana_word[ANA_INV_RX] = inv_rx_r;
      ana_word[ANA_VSEL_LO +: ANA_VSEL_W] = vsel_r;
   end

   always_comb begin
      rd_hit = 1'b1;
      case (S_AXI_ARADDR_IN)
         PPPR_OFS_POLICY: rd_nxt = pol_word;
         PPPR_OFS_ANALOG: rd_nxt = ana_word;
         PPPR_OFS_STATUS: rd_nxt = {29'h0, auto_saver, var_done, ld_done};
         PPPR_OFS_NVM:    rd_nxt = {16'h0, nvm_word};
         default: begin
            rd_nxt = '0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // reads held off until nvm defaults are loaded
   // no handshake while ce is low, or the request would be lost
   assign S_AXI_ARREADY_OUT = CE_IN && ld_done && !S_AXI_RVALID_OUT;
   assign rd_fire = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_RDATA_OUT  <= '0;
         S_AXI_RRESP_OUT  <= AXI_OKAY;
      end else if (CE_IN) begin
         if (rd_fire) begin
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RDATA_OUT  <= rd_nxt;
            S_AXI_RRESP_OUT  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
         end else if (S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
         end
      end
   end

   // ==========================================================
   // power policy decode
   assign active_state = (POWER_STATE_IN == PWR_D0A);
   assign d3_state     = (POWER_STATE_IN == PWR_D3HOT) || (POWER_STATE_IN == PWR_D3COLD);
   assign auto_saver   = !no_auto_r && d3_state && !LINK_UP_IN;

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         POLICY_OUT <= '0;
      end else if (CE_IN) begin
         POLICY_OUT.gig_disable <= gig_all_r ||
                                   (gig_nact_r && !active_state);
         POLICY_OUT.slowest_link <= slow_all_r ||
                                    (slow_nact_r && !active_state);
         POLICY_OUT.smart_power_down   <= spd_r;
         POLICY_OUT.b2b_power_down     <= spd_r && b2b_r;
         POLICY_OUT.battery_saver_flow <= auto_saver || bs_act_r;
         POLICY_OUT.power_ctl_pin      <= bs_act_r;
      end
   end

   // general-purpose unit feed
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         INVERT_RX_OUT   <= 1'b0;
         VOLTAGE_SEL_OUT <= ANA_VSEL_RESET;
      end else if (CE_IN) begin
         INVERT_RX_OUT   <= inv_rx_r;
         VOLTAGE_SEL_OUT <= vsel_r;
      end
   end
endmodule
`default_nettype wire

// File: shared/pppr_pkg.sv
/*
 * package for the transceiver power policy register bank: offsets,
 * field positions, reset values, nvm word layout and carrier structs.
 * assumes a 32-bit axi4-lite register bus and one 50 mhz clock.
 */
`default_nettype none
package pppr_pkg;
   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [11:0] PPPR_OFS_POLICY = 12'hf10;
   localparam logic [11:0] PPPR_OFS_ANALOG = 12'hf18;
   localparam logic [11:0] PPPR_OFS_STATUS = 12'hf1c;
   localparam logic [11:0] PPPR_OFS_NVM    = 12'hf20;
   localparam int          PPPR_ADDR_W     = 12;

   // ==========================================================
   // policy register field positions
   localparam int POL_SPD_EN    = 0;
   localparam int POL_SLOW_ALL  = 1;
   localparam int POL_SLOW_NACT = 2;
   localparam int POL_GIG_NACT  = 3;
   localparam int POL_GIG_ALL   = 6;
   localparam int POL_B2B_EN    = 7;
   localparam int POL_BS_ACT    = 16;
   localparam int POL_RSV_LO    = 17;
   localparam int POL_NO_AUTO   = 21;
   localparam int POL_VAR_DONE  = 23;
   localparam int POL_VAR_LO    = 25;
   localparam int POL_VAR_W     = 4;
   localparam logic [3:0] POL_RSV_RESET = 4'h2;   // bits 20:17

   // ==========================================================
   // analog config fields
   localparam int          ANA_INV_RX    = 0;
   localparam int          ANA_VSEL_LO   = 1;
   localparam int          ANA_VSEL_W    = 6;
   localparam logic [5:0]  ANA_VSEL_RESET = 6'h20;

   // ==========================================================
   // nvm word 17h and 18h bit positions and word addresses
   localparam logic [7:0] NVM_WORD_POLICY = 8'h17;
   localparam logic [7:0] NVM_WORD_ANALOG = 8'h18;
   localparam int NVM_B2B      = 15;
   localparam int NVM_GIG_ALL  = 14;
   localparam int NVM_GIG_NACT = 11;
   localparam int NVM_SLOW_NACT = 10;
   localparam int NVM_SLOW_ALL = 9;
   localparam int NVM_SPD      = 8;
   localparam int NVM_INV_RX   = 0;

   // ==========================================================
   // axi responses
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   // power state of the mac
   typedef enum logic [2:0] {
      PWR_D0A, PWR_D0U, PWR_DR, PWR_D3HOT, PWR_D3COLD
   } pppr_pwr_t;

   // policy outputs toward the transceiver
   typedef struct packed {
      logic gig_disable;
      logic slowest_link;
      logic smart_power_down;
      logic b2b_power_down;
      logic battery_saver_flow;
      logic power_ctl_pin;
   } pppr_policy_t;

   // nvm read request and answer
   typedef struct packed {
      logic       req;
      logic [7:0] addr;
   } pppr_nvm_req_t;

   typedef struct packed {
      logic        ack;
      logic [15:0] data;
   } pppr_nvm_rsp_t;
endpackage
`default_nettype wire

// File: design/pppr_nvm_loader.sv
/*
 * nvm loader: after reset reads word 17h then 18h and hands the bits
 * to the register bank. assumes an nvm port that acks with data.
 */
`default_nettype none
module pppr_nvm_loader
   import pppr_pkg::*;
(
   input  wire logic          clk_in,
   input  wire logic          rst_in,
   input  wire logic          ce_in,
   output pppr_nvm_req_t      nvm_req_out,
   input  wire pppr_nvm_rsp_t nvm_rsp_in,
   output logic [15:0]        word_out,
   output logic               policy_ld_out,
   output logic               analog_ld_out,
   output logic               done_out
);
   typedef enum logic [1:0] {LD_POL, LD_ANA, LD_DONE} pppr_ld_t;
   pppr_ld_t st_r;

   // ==========================================================
   // sequencer
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_r <= LD_POL;
      end else if (ce_in && nvm_rsp_in.ack) begin
         case (st_r)
            LD_POL:  st_r <= LD_ANA;
            LD_ANA:  st_r <= LD_DONE;
            default: st_r <= LD_DONE;
         endcase
      end
   end

   assign nvm_req_out.req  = (st_r != LD_DONE);
   assign nvm_req_out.addr = (st_r == LD_ANA) ? NVM_WORD_ANALOG : NVM_WORD_POLICY;
   assign word_out         = nvm_rsp_in.data;
   assign policy_ld_out    = ce_in && nvm_rsp_in.ack && (st_r == LD_POL);
   assign analog_ld_out    = ce_in && nvm_rsp_in.ack && (st_r == LD_ANA);
   assign done_out         = (st_r == LD_DONE);
endmodule
`default_nettype wire

// File: design/pppr_variant_read.sv
/*
 * variant code capture: waits for the transceiver read strobe,
 * latches the four-bit code and flags completion until reset.
 */
`default_nettype none
module pppr_variant_read
   import pppr_pkg::*;
#(
   parameter int W = POL_VAR_W
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         ce_in,
   input  wire logic         valid_in,
   input  wire logic [W-1:0] code_in,
   output logic [W-1:0]      code_out,
   output logic              done_out
);
   // ==========================================================
   // capture the first code only
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         code_out <= '0;
         done_out <= 1'b0;
      end else if (ce_in && valid_in && !done_out) begin
         code_out <= code_in;
         done_out <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: test/pppr_nvm_model.sv
/*
 * nvm model for the power policy bank: answers each read with a pulse.
 * assumes the bank holds req and addr until its ack arrives.
 */
`default_nettype none
module pppr_nvm_model
   import pppr_pkg::*;
(
   input  wire logic          clk_in,
   input  wire logic          rst_in,
   input  wire pppr_nvm_req_t req_in,
   input  wire logic [15:0]   w17_in,
   input  wire logic [15:0]   w18_in,
   output pppr_nvm_rsp_t      rsp_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt_r = 2'h0;
   logic [1:0] wait_r = 2'h0;
   initial rsp_out = '0;
   // ==========
   // wait 0..3 cycles per word, data toggles when not answering
   always @(posedge clk_in) begin
      rsp_out.ack <= 1'b0;
      rsp_out.data <= ~rsp_out.data;
      if (rst_in) begin
         cnt_r <= 2'h0;
      end else if (req_in.req && !rsp_out.ack) begin
         cnt_r <= cnt_r + 2'h1;
         if (cnt_r == wait_r) begin
            rsp_out.ack <= 1'b1;
            rsp_out.data <= (req_in.addr == NVM_WORD_POLICY) ? w17_in : w18_in;
            cnt_r <= 2'h0;
            wait_r <= wait_r + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: test/pppr_top_sva.sv
/*
 * checker for the power policy bank, watching top ports only.
 * assumes one clock and a synchronous active-high reset.
 */
`default_nettype none
module pppr_top_sva
   import pppr_pkg::*;
(
   input  wire logic                   CLOCK_IN,
   input  wire logic                   RST_IN,
   input  wire logic [PPPR_ADDR_W-1:0] S_AXI_ARADDR_IN,
   input  wire logic                   S_AXI_ARVALID_IN,
   input  wire logic                   S_AXI_ARREADY_OUT,
   input  wire logic [31:0]            S_AXI_RDATA_OUT,
   input  wire logic [1:0]             S_AXI_RRESP_OUT,
   input  wire logic                   S_AXI_RVALID_OUT,
   input  wire pppr_nvm_req_t          NVM_REQ_OUT,
   input  wire pppr_pwr_t              POWER_STATE_IN,
   input  wire pppr_policy_t           POLICY_OUT,
   input  wire logic                   INVERT_RX_OUT,
   input  wire logic [ANA_VSEL_W-1:0]  VOLTAGE_SEL_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rd_pol_r;
   logic rd_ana_r;
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (RST_IN);
   // ==========
   // remember which register the pending read targets
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         rd_pol_r <= 1'b0;
         rd_ana_r <= 1'b0;
      end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
         rd_pol_r <= (S_AXI_ARADDR_IN == PPPR_OFS_POLICY);
         rd_ana_r <= (S_AXI_ARADDR_IN == PPPR_OFS_ANALOG);
      end
   end
   // ==========
   // reset, load and readback relations
   AST_RST_POL: assert property (disable iff (1'b0) RST_IN |=>
      POLICY_OUT == '0 && VOLTAGE_SEL_OUT == ANA_VSEL_RESET) else $error("reset values wrong");
   AST_RST_NVM: assert property (disable iff (1'b0) RST_IN |=>
      NVM_REQ_OUT.req && NVM_REQ_OUT.addr == NVM_WORD_POLICY) else $error("no nvm load");
   AST_AR_LOAD: assert property (NVM_REQ_OUT.req |-> !S_AXI_ARREADY_OUT)
      else $error("read taken before load");
   AST_R_ANSWER: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |->
      ##[1:2] S_AXI_RVALID_OUT) else $error("read not answered");
   AST_ANA_READ: assert property (S_AXI_RVALID_OUT && rd_ana_r |->
      S_AXI_RDATA_OUT[31:7] == '0 && S_AXI_RDATA_OUT[6:1] == VOLTAGE_SEL_OUT
      && S_AXI_RDATA_OUT[0] == INVERT_RX_OUT) else $error("analog readback wrong");
   AST_POL_RSV: assert property (S_AXI_RVALID_OUT && rd_pol_r |->
      S_AXI_RDATA_OUT[31:29] == 3'h0 && S_AXI_RDATA_OUT[24] == 1'b0
      && S_AXI_RDATA_OUT[22] == 1'b0 && S_AXI_RDATA_OUT[20:17] == POL_RSV_RESET
      && S_AXI_RDATA_OUT[15:8] == 8'h00 && S_AXI_RDATA_OUT[5:4] == 2'h0
      && S_AXI_RRESP_OUT == AXI_OKAY) else $error("policy fixed bits wrong");
   AST_POL_TIE: assert property (S_AXI_RVALID_OUT && rd_pol_r |->
      S_AXI_RDATA_OUT[16] == POLICY_OUT.power_ctl_pin
      && S_AXI_RDATA_OUT[0] == POLICY_OUT.smart_power_down) else $error("policy out mismatch");
   AST_GIG_ACT: assert property (S_AXI_RVALID_OUT && rd_pol_r
      && $past(POWER_STATE_IN) == PWR_D0A && $stable(POWER_STATE_IN) |->
      POLICY_OUT.gig_disable == S_AXI_RDATA_OUT[6]
      && POLICY_OUT.slowest_link == S_AXI_RDATA_OUT[1]) else $error("active speed wrong");
   AST_PIN_SAVER: assert property (POLICY_OUT.power_ctl_pin |->
      POLICY_OUT.battery_saver_flow) else $error("pin without saver");
   AST_B2B_SPD: assert property (POLICY_OUT.b2b_power_down |->
      POLICY_OUT.smart_power_down) else $error("b2b without spd");
endmodule
bind pppr_top pppr_top_sva u_sva (
   .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .S_AXI_ARADDR_IN(S_AXI_ARADDR_IN),
   .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN), .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
   .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT), .S_AXI_RRESP_OUT(S_AXI_RRESP_OUT),
   .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .NVM_REQ_OUT(NVM_REQ_OUT),
   .POWER_STATE_IN(POWER_STATE_IN), .POLICY_OUT(POLICY_OUT),
   .INVERT_RX_OUT(INVERT_RX_OUT), .VOLTAGE_SEL_OUT(VOLTAGE_SEL_OUT)
);
`default_nettype wire

// File: test/pppr_top_tb.sv
/*
 * testbench for the power policy bank: axi4-lite master, nvm model,
 * transceiver stimulus. assumes the design and package as declared.
 */
`default_nettype none
module pppr_top_tb
   import pppr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, d, m, pol_r, ana_r;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic vvalid = 1'b0, ce = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, inv, link = 1'b0;
   logic [1:0] bresp, rresp;
   logic [3:0] vcode = '0, code, wstrb = 4'hf, ws = 4'hf;
   logic [5:0] vsel;
   logic [15:0] w17, w18;
   pppr_pwr_t pstate = PWR_D0A;
   pppr_nvm_req_t nreq;
   pppr_nvm_rsp_t nrsp;
   pppr_policy_t pol;
   int failures = 0, cmp_count = 0, seed = 89463;
   logic [33:0] rq[$];
   logic [1:0] bq[$];

   always #10 clk = ~clk;
   pppr_top u_dut (.CLOCK_IN(clk), .RST_IN(rst), .CE_IN(ce),
      .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
      .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
      .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
      .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
      .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
      .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .NVM_REQ_OUT(nreq),
      .NVM_RSP_IN(nrsp), .VARIANT_VALID_IN(vvalid), .VARIANT_CODE_IN(vcode),
      .POWER_STATE_IN(pstate), .LINK_UP_IN(link), .POLICY_OUT(pol),
      .INVERT_RX_OUT(inv), .VOLTAGE_SEL_OUT(vsel));
   pppr_nvm_model u_nvm (.clk_in(clk), .rst_in(rst), .req_in(nreq), .w17_in(w17),
      .w18_in(w18), .rsp_out(nrsp));

   // ==========
   // compare, verdict and expected-value helpers
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   function automatic logic [31:0] pol_nvm(input logic [15:0] w);
      pol_nvm = {11'h0, 4'h2, 9'h0, w[15:14], 2'h0, w[11:8]};
   endfunction
   function automatic pppr_policy_t exp_pol(input logic [31:0] r, input pppr_pwr_t s,
                                            input logic l);
      logic na;
      na = (s != PWR_D0A);
      exp_pol.gig_disable = r[6] | (r[3] & na);
      exp_pol.slowest_link = r[1] | (r[2] & na);
      exp_pol.smart_power_down = r[0];
      exp_pol.b2b_power_down = r[0] & r[7];
      exp_pol.battery_saver_flow = (!r[21] & !l & (s == PWR_D3HOT || s == PWR_D3COLD)) | r[16];
      exp_pol.power_ctl_pin = r[16];
   endfunction

   // ==========
   // bus master tasks: hold each channel until its handshake edge
   task automatic axi_write(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
      logic hb;
      bq.push_back(er);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      wstrb <= ws;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      hb = 1'b0;
      while (!hb) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         hb = (bvalid === 1'b1);
      end
      bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [11:0] a, input logic [33:0] e);
      logic hr;
      rq.push_back(e);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      hr = 1'b0;
      while (!hr) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         hr = (rvalid === 1'b1);
      end
      rready <= 1'b0;
   endtask
   task automatic check_pol(input pppr_pwr_t s, input logic l);
      @(posedge clk);
      pstate <= s;
      link <= l;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({28'h0, pol}, {28'h0, exp_pol(pol_r, s, l)});
   endtask
   task automatic do_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      pol_r = pol_nvm(w17);
      ana_r = {25'h0, 6'h20, w18[0]};
   endtask

   // ==========
   // monitor: oldest note against each response
   always @(posedge clk) begin
      if (rvalid === 1'b1 && rready && rq.size() > 0) check({rresp, rdata}, rq.pop_front());
      if (bvalid === 1'b1 && bready && bq.size() > 0) check({32'h0, bresp}, {32'h0, bq.pop_front()});
   end

   // ==========
   // watchdog against a hang
   initial begin
      repeat (8000) @(posedge clk);
      failures++;
      give_verdict;
   end

   // ==========
   // main sequence
   initial begin
      w17 = 16'($random(seed));
      w18 = 16'($random(seed));
      do_reset;
      axi_read(PPPR_OFS_POLICY, {AXI_OKAY, pol_r});
      axi_read(PPPR_OFS_ANALOG, {AXI_OKAY, ana_r});
      code = 4'($random(seed));
      @(posedge clk);
      vcode <= code;
      vvalid <= 1'b1;
      @(posedge clk);
      vcode <= ~code; // a second strobe must not replace the code
      @(posedge clk);
      vvalid <= 1'b0;
      pol_r[28:25] = code;
      pol_r[23] = 1'b1;
      axi_read(PPPR_OFS_POLICY, {AXI_OKAY, pol_r});
      axi_read(PPPR_OFS_STATUS, {AXI_OKAY, 32'h0000_0003});
      axi_write(PPPR_OFS_ANALOG, 32'hffff_ffff, AXI_OKAY);
      axi_read(PPPR_OFS_ANALOG, {AXI_OKAY, 32'h0000_007f});
      check({27'h0, vsel, inv}, {27'h0, 7'h7f});
      d = $random(seed);
      axi_write(PPPR_OFS_ANALOG, d, AXI_OKAY);
      axi_read(PPPR_OFS_ANALOG, {AXI_OKAY, d & 32'h0000_007f});
      axi_read(12'h004, {AXI_SLVERR, 32'h0});
      axi_write(12'h004, d, AXI_SLVERR);
      for (int i = 0; i < 10; i++) begin
         if (i > 0) begin
            d = $random(seed);
            d[3] = 1'b1;
            ws = 4'($random(seed));
            axi_write(PPPR_OFS_POLICY, d, AXI_OKAY);
            m = (ws[0] ? 32'h0000_00cf : 32'h0) | (ws[2] ? 32'h0021_0000 : 32'h0);
            pol_r = (d & m) | (pol_r & ~m);
            axi_read(PPPR_OFS_POLICY, {AXI_OKAY, pol_r});
         end
         for (int s = 0; s < 5; s++) begin
            check_pol(pppr_pwr_t'(s), 1'b0);
            check_pol(pppr_pwr_t'(s), 1'b1);
         end
      end
      // clock enable low: policy outputs must stay frozen
      @(posedge clk);
      ce <= 1'b0;
      pstate <= PWR_D0A;
      link <= 1'b0;
      repeat (3) @(posedge clk);
      check({28'h0, pol}, {28'h0, exp_pol(pol_r, PWR_D3COLD, 1'b1)});
      ce <= 1'b1;
      do_reset;
      axi_read(PPPR_OFS_POLICY, {AXI_OKAY, pol_r});
      axi_read(PPPR_OFS_ANALOG, {AXI_OKAY, ana_r});
      give_verdict;
   end
endmodule
`default_nettype wire
